// file: rtl/mcu_exec_regs.vh
`ifndef MCU_EXEC_REGS_VH
`define MCU_EXEC_REGS_VH
// ============================================================
// operation codes on the decoded op input
`define OP_NONE       4'h0
`define OP_SUB_ACC    4'h1
`define OP_SUB_MEM    4'h2
`define OP_SUB_IMM    4'h3
`define OP_SWAP_MEM   4'h4
`define OP_SWAP_ACC   4'h5
`define OP_SKIP_ZERO  4'h6
`define OP_MOVE_SKIP  4'h7
`define OP_BIT_ZERO   4'h8
`define OP_BIT_SET    4'h9
`define OP_TAB_CUR    4'hA
`define OP_TAB_LAST   4'hB
`define OP_XOR_ACC    4'hC
`define OP_XOR_MEM    4'hD
`define OP_XOR_IMM    4'hE
// ============================================================
// status flag bit positions
`define FLAG_CARRY    0
`define FLAG_HALF     1
`define FLAG_ZERO     2
`define FLAG_OVER     3
`define FLAG_POWER    4
`define FLAG_WDT      5
`define FLAG_TMR1     6
`define FLAG_TMR2     7
// ============================================================
// reset values
`define STATUS_RESET  8'h00
`define ACC_RESET     8'h00
`define TABLE_HIGH_LATCH_RESET    8'h00
// ============================================================
// timing counts in instruction cycles
`define SKIP_CYCLES   2
`define PLAIN_CYCLES  1
`endif

// file: rtl/sub_adder.v
`default_nettype none
// ============================================================
// a + ~b + 1 with carry, half carry and overflow
module sub_adder #(
  parameter WIDTH = 8
) (
  input wire [WIDTH-1:0] a,
  input wire [WIDTH-1:0] b,
  output wire [WIDTH-1:0] diff,
  output wire carry,
  output wire half_carry,
  output wire overflow
);
  wire [WIDTH-1:0] nb;
  wire [WIDTH:0] full;
  wire [4:0] low;
  assign nb = ~b;
  assign full = {1'b0, a} + {1'b0, nb} + {{WIDTH{1'b0}}, 1'b1};
  assign low = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + 5'h01;
  assign diff = full[WIDTH-1:0];
  assign carry = full[WIDTH];
  assign half_carry = low[4];
  assign overflow = (a[WIDTH-1] == nb[WIDTH-1]) && (diff[WIDTH-1] != a[WIDTH-1]);
endmodule
`default_nettype wire

// file: rtl/mcu_subtract_swap_skip_xor_exec.v
// Summary of operation
// - register subtract forms compute acc + ~mem + 1 into acc or mem and update overflow, zero, half carry, carry.
// - immediate subtract computes acc + ~imm + 1 into acc and updates overflow, zero, half carry, carry.
// - in-place swap exchanges the nibbles of the memory byte, writes it back, no flag changes.
// - accumulator swap loads acc with the nibble-swapped memory byte, memory and flags untouched.
// - a true skip discards the prefetched instruction and adds a dummy cycle, 2 cycles, else 1 cycle.
// - byte skip-when-zero skips when the memory byte is zero and changes neither memory nor flags.
// - move-and-skip copies the memory byte to acc and skips when it is zero, flags untouched.
// - bit-zero test skips when the selected bit is zero, memory and flags untouched.
// - bit-set test skips when the selected bit is one, no flag changes, same skip timing.
// - current-page table read sends the low byte of the word to memory and the high byte to the latch.
// - last-page table read does the same for the word in the last program page.
// - register xor stores acc ^ mem in acc.
// - memory xor writes acc ^ mem back to the memory byte.
// - immediate xor stores acc ^ imm in acc.
// - all xor forms update only the zero flag.
`include "mcu_exec_regs.vh"
`default_nettype none
module mcu_subtract_swap_skip_xor_exec #(
  parameter ROM_ADDR_W = 13,
  parameter PAGE_BITS = 8
) (
  // clock and reset
  input wire SYS_CLK,
  input wire RSTN,
  // decoded instruction
  input wire OP_VALID,
  input wire [3:0] OP_CODE,
  input wire [7:0] IMM_DATA,
  input wire [2:0] BIT_SEL,
  input wire [7:0] MEM_RDATA,
  // program counter and table pointer
  input wire [ROM_ADDR_W-1:0] PC,
  input wire [PAGE_BITS-1:0] TABLE_POINTER,
  // program memory table port
  output wire [ROM_ADDR_W-1:0] ROM_ADDR,
  output wire ROM_RD,
  input wire [15:0] ROM_DATA,
  // data memory write
  output reg MEM_WE,
  output reg [7:0] MEM_WDATA,
  // timer and power flags set elsewhere
  input wire TIMER_FLAG_ONE_IN,
  input wire TIMER_FLAG_TWO_IN,
  input wire WATCHDOG_TIMEOUT_IN,
  input wire POWER_DOWN_IN,
  // state
  output reg [7:0] ACC,
  output reg [7:0] STATUS,
  output reg [7:0] TABLE_HIGH_LATCH,
  // fetch control
  output wire BUSY,
  output reg DISCARD_PREFETCH
);
  // ============================================================
  // sequencer
  localparam ST_EXEC = 2'b01;
  localparam ST_DUMMY = 2'b10;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] next_acc;
  reg [7:0] next_status;
  reg [7:0] next_table_high_latch;
  reg next_we;
  reg [7:0] next_wdata;
  reg skip;
  wire accept;
  wire is_sub_acc;
  wire is_sub_mem;
  wire is_sub_imm;
  wire is_swap_mem;
  wire is_swap_acc;
  wire is_skip_zero;
  wire is_move_skip;
  wire is_bit_zero;
  wire is_bit_set;
  wire is_tab_cur;
  wire is_tab_last;
  wire is_xor_acc;
  wire is_xor_mem;
  wire is_xor_imm;
  wire is_sub;
  wire is_xor;
  wire is_table;
  wire [7:0] diff_op;
  wire [7:0] xor_op;
  wire [7:0] sub_diff;
  wire sub_c;
  wire sub_h;
  wire sub_v;
  wire [7:0] xor_val;
  wire [7:0] swapped;
  wire sel_bit;
  wire byte_zero;
  wire table_op;
  wire [ROM_ADDR_W-PAGE_BITS-1:0] cur_page;
  wire [ROM_ADDR_W-PAGE_BITS-1:0] last_page;
  reg [ROM_ADDR_W-1:0] rom_addr_sel;

  // ============================================================
  // instruction decode
  assign is_sub_acc = (OP_CODE == `OP_SUB_ACC);
  assign is_sub_mem = (OP_CODE == `OP_SUB_MEM);
  assign is_sub_imm = (OP_CODE == `OP_SUB_IMM);
  assign is_swap_mem = (OP_CODE == `OP_SWAP_MEM);
  assign is_swap_acc = (OP_CODE == `OP_SWAP_ACC);
  assign is_skip_zero = (OP_CODE == `OP_SKIP_ZERO);
  assign is_move_skip = (OP_CODE == `OP_MOVE_SKIP);
  assign is_bit_zero = (OP_CODE == `OP_BIT_ZERO);
  assign is_bit_set = (OP_CODE == `OP_BIT_SET);
  assign is_tab_cur = (OP_CODE == `OP_TAB_CUR);
  assign is_tab_last = (OP_CODE == `OP_TAB_LAST);
  assign is_xor_acc = (OP_CODE == `OP_XOR_ACC);
  assign is_xor_mem = (OP_CODE == `OP_XOR_MEM);
  assign is_xor_imm = (OP_CODE == `OP_XOR_IMM);
  assign is_sub = is_sub_acc || is_sub_mem || is_sub_imm;
  assign is_xor = is_xor_acc || is_xor_mem || is_xor_imm;
  assign is_table = is_tab_cur || is_tab_last;

  // ============================================================
  // operands
  // ops presented in the dummy cycle are refused
  assign accept = OP_VALID && (state == ST_EXEC);
  assign BUSY = (state == ST_DUMMY);
  assign diff_op = is_sub_imm ? IMM_DATA : MEM_RDATA;
  assign xor_op = is_xor_imm ? IMM_DATA : MEM_RDATA;
  assign xor_val = ACC ^ xor_op;
  assign swapped = {MEM_RDATA[3:0], MEM_RDATA[7:4]};
  assign sel_bit = MEM_RDATA[BIT_SEL];
  assign byte_zero = (MEM_RDATA == 8'h00);
  assign table_op = accept && is_table;

  // ============================================================
  // table address
  // current page from the pc, last page all ones
  assign cur_page = PC[ROM_ADDR_W-1:PAGE_BITS];
  assign last_page = {(ROM_ADDR_W-PAGE_BITS){1'b1}};
  always @* begin
    if (is_tab_last) begin
      rom_addr_sel = {last_page, TABLE_POINTER};
    end else begin
      rom_addr_sel = {cur_page, TABLE_POINTER};
    end
  end
  assign ROM_ADDR = rom_addr_sel;
  assign ROM_RD = table_op;

  sub_adder #(
    .WIDTH(8)
  ) u_sub (
    .a(ACC),
    .b(diff_op),
    .diff(sub_diff),
    .carry(sub_c),
    .half_carry(sub_h),
    .overflow(sub_v)
  );

  // ============================================================
  // accumulator
  always @* begin
    next_acc = ACC;
    if (accept) begin
      if (is_sub_acc) begin
        next_acc = sub_diff;
      end else if (is_sub_imm) begin
        next_acc = sub_diff;
      end else if (is_swap_acc) begin
        next_acc = swapped;
      end else if (is_move_skip) begin
        next_acc = MEM_RDATA;
      end else if (is_xor_acc) begin
        next_acc = xor_val;
      end else if (is_xor_imm) begin
        next_acc = xor_val;
      end
    end
  end

  // ============================================================
  // data memory write
  always @* begin
    next_we = 1'b0;
    next_wdata = MEM_WDATA;
    if (accept) begin
      if (is_sub_mem) begin
        next_we = 1'b1;
        next_wdata = sub_diff;
      end else if (is_swap_mem) begin
        next_we = 1'b1;
        next_wdata = swapped;
      end else if (is_tab_cur) begin
        next_we = 1'b1;
        next_wdata = ROM_DATA[7:0];
      end else if (is_tab_last) begin
        next_we = 1'b1;
        next_wdata = ROM_DATA[7:0];
      end else if (is_xor_mem) begin
        next_we = 1'b1;
        next_wdata = xor_val;
      end
    end
  end

  // ============================================================
  // table high latch
  always @* begin
    next_table_high_latch = TABLE_HIGH_LATCH;
    if (table_op && is_tab_cur) begin
      next_table_high_latch = ROM_DATA[15:8];
    end else if (table_op && is_tab_last) begin
      next_table_high_latch = ROM_DATA[15:8];
    end
  end

  // ============================================================
  // status flags
  always @* begin
    next_status = STATUS;
    // timer and power bits follow their owners
    next_status[`FLAG_TMR1] = TIMER_FLAG_ONE_IN;
    next_status[`FLAG_TMR2] = TIMER_FLAG_TWO_IN;
    next_status[`FLAG_WDT] = WATCHDOG_TIMEOUT_IN;
    next_status[`FLAG_POWER] = POWER_DOWN_IN;
    // carry set means no borrow
    if (accept && is_sub) begin
      next_status[`FLAG_OVER] = sub_v;
      next_status[`FLAG_ZERO] = (sub_diff == 8'h00);
      next_status[`FLAG_HALF] = sub_h;
      next_status[`FLAG_CARRY] = sub_c;
    end else if (accept && is_xor) begin
      next_status[`FLAG_ZERO] = (xor_val == 8'h00);
    end
  end

  // ============================================================
  // skip decision
  always @* begin
    skip = 1'b0;
    if (accept) begin
      if (is_skip_zero) begin
        skip = byte_zero;
      end else if (is_move_skip) begin
        skip = byte_zero;
      end else if (is_bit_zero) begin
        skip = ~sel_bit;
      end else if (is_bit_set) begin
        skip = sel_bit;
      end
    end
  end

  // skip inserts one dummy cycle
  always @* begin
    case (state)
      ST_EXEC: next_state = skip ? ST_DUMMY : ST_EXEC;
      ST_DUMMY: next_state = ST_EXEC;
      default: next_state = ST_EXEC;
    endcase
  end

  // ============================================================
  // registers
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= ST_EXEC;
      DISCARD_PREFETCH <= 1'b0;
    end else begin
      state <= next_state;
      DISCARD_PREFETCH <= skip;
    end
  end

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ACC <= `ACC_RESET;
    end else begin
      ACC <= next_acc;
    end
  end

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      STATUS <= `STATUS_RESET;
    end else begin
      STATUS <= next_status;
    end
  end

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      TABLE_HIGH_LATCH <= `TABLE_HIGH_LATCH_RESET;
    end else begin
      TABLE_HIGH_LATCH <= next_table_high_latch;
    end
  end

  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_WE <= 1'b0;
      MEM_WDATA <= 8'h00;
    end else begin
      MEM_WE <= next_we;
      MEM_WDATA <= next_wdata;
    end
  end
endmodule
`default_nettype wire

// file: dv/exec_check_sva.sv
`include "mcu_exec_regs.vh"
`default_nettype none
module exec_check (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic OP_VALID,
  input wire logic [3:0] OP_CODE,
  input wire logic [7:0] IMM_DATA,
  input wire logic [2:0] BIT_SEL,
  input wire logic [7:0] MEM_RDATA,
  input wire logic [15:0] ROM_DATA,
  input wire logic MEM_WE,
  input wire logic [7:0] MEM_WDATA,
  input wire logic [7:0] ACC,
  input wire logic [7:0] STATUS,
  input wire logic [7:0] TABLE_HIGH_LATCH,
  input wire logic BUSY,
  input wire logic DISCARD_PREFETCH
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  wire logic tk = OP_VALID && !BUSY;
  wire logic sel = MEM_RDATA[BIT_SEL];
  wire logic [7:0] sw = {MEM_RDATA[3:0], MEM_RDATA[7:4]};
  a_sub_imm_carry: assert property (tk && OP_CODE == `OP_SUB_IMM |=> ACC == $past(ACC) - $past(IMM_DATA)
    && STATUS[`FLAG_CARRY] == ($past(ACC) >= $past(IMM_DATA))) else $error("immediate subtract wrong");
  a_sub_mem_write: assert property (tk && OP_CODE == `OP_SUB_MEM |=> MEM_WE
    && MEM_WDATA == $past(ACC) - $past(MEM_RDATA) && $stable(ACC)) else $error("memory subtract wrong");
  a_swap_mem_write: assert property (tk && OP_CODE == `OP_SWAP_MEM |=> MEM_WE
    && MEM_WDATA == $past(sw) && $stable(STATUS[3:0])) else $error("memory swap wrong");
  a_swap_acc_load: assert property (tk && OP_CODE == `OP_SWAP_ACC |=> !MEM_WE
    && ACC == $past(sw) && $stable(STATUS[3:0])) else $error("accumulator swap wrong");
  a_zero_skip: assert property (tk && (OP_CODE == `OP_SKIP_ZERO || OP_CODE == `OP_MOVE_SKIP)
    |=> DISCARD_PREFETCH == ($past(MEM_RDATA) == 8'h00)) else $error("byte skip wrong");
  a_bit_skip: assert property (tk && (OP_CODE == `OP_BIT_ZERO || OP_CODE == `OP_BIT_SET)
    |=> DISCARD_PREFETCH == ($past(sel) ^ ($past(OP_CODE) == `OP_BIT_ZERO))) else $error("bit skip wrong");
  a_skip_dummy_len: assert property (DISCARD_PREFETCH |-> BUSY ##1 (!BUSY && !DISCARD_PREFETCH))
    else $error("dummy cycle length wrong");
  a_xor_zero_only: assert property (tk && OP_CODE == `OP_XOR_IMM |=> ACC == ($past(ACC) ^ $past(IMM_DATA))
    && STATUS[`FLAG_ZERO] == (ACC == 8'h00) && $stable(STATUS[1:0]) && $stable(STATUS[3])) else $error("xor wrong");
  a_table_split: assert property (tk && (OP_CODE == `OP_TAB_CUR || OP_CODE == `OP_TAB_LAST) |=> MEM_WE
    && MEM_WDATA == $past(ROM_DATA[7:0]) && TABLE_HIGH_LATCH == $past(ROM_DATA[15:8])) else $error("table read wrong");
endmodule
bind mcu_subtract_swap_skip_xor_exec exec_check chk_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .IMM_DATA(IMM_DATA), .BIT_SEL(BIT_SEL), .MEM_RDATA(MEM_RDATA), .ROM_DATA(ROM_DATA),
  .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .ACC(ACC), .STATUS(STATUS), .TABLE_HIGH_LATCH(TABLE_HIGH_LATCH),
  .BUSY(BUSY), .DISCARD_PREFETCH(DISCARD_PREFETCH));
`default_nettype wire

// file: dv/mcu_subtract_swap_skip_xor_exec_bench.sv
`include "mcu_exec_regs.vh"
`default_nettype none
module mcu_subtract_swap_skip_xor_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0, flags_in = 4'h0;
  logic [7:0] imm_data = 8'h00, mem_rdata = 8'h00, tptr = 8'h00, acc_x = 8'h00, acc, status, table_high_latch, mem_wdata;
  logic [2:0] bit_sel = 3'h0;
  logic [12:0] pc = 13'h0000, rom_addr, ra;
  logic [15:0] rom_data = 16'h0000;
  logic rom_rd, mem_we, busy, discard, rr;
  logic [15:0] tbl [8] = '{16'h6100, 16'h6001, 16'h7100, 16'h7040, 16'h81FE, 16'h8001, 16'h9F80, 16'h9E7F};
  int err_count = 0, n_tests = 0, cyc = 0;
  mcu_subtract_swap_skip_xor_exec dut_u (.SYS_CLK(sys_clk), .RSTN(rstn), .OP_VALID(op_valid), .OP_CODE(op_code),
    .IMM_DATA(imm_data), .BIT_SEL(bit_sel), .MEM_RDATA(mem_rdata), .PC(pc), .TABLE_POINTER(tptr),
    .ROM_ADDR(rom_addr), .ROM_RD(rom_rd), .ROM_DATA(rom_data), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata),
    .TIMER_FLAG_ONE_IN(flags_in[2]), .TIMER_FLAG_TWO_IN(flags_in[3]), .WATCHDOG_TIMEOUT_IN(flags_in[1]),
    .POWER_DOWN_IN(flags_in[0]), .ACC(acc), .STATUS(status), .TABLE_HIGH_LATCH(table_high_latch), .BUSY(busy),
    .DISCARD_PREFETCH(discard));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    flags_in <= flags_in + 4'h1;
    cyc <= cyc + 1;
    if (cyc == 400) begin
      err_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one instruction; keep leaves it presented into the next cycle
  task automatic run(input logic [3:0] c, input logic [7:0] m, input logic [7:0] i, input logic [2:0] b,
                     input logic keep);
    @(posedge sys_clk);
    {op_code, mem_rdata, imm_data, bit_sel, op_valid, rom_data, pc, tptr} <= {c, m, i, b, 1'b1, i, m, i[4:0], 8'h00, m};
    @(negedge sys_clk);
    {ra, rr} = {rom_addr, rom_rd};
    @(posedge sys_clk);
    op_valid <= keep;
    #1;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    run(`OP_XOR_IMM, 8'h00, 8'h80, 3'h0, 1'b0);
    chk({acc, 4'h0, status[3:0]}, 16'h8000);
    chk({12'h000, status[7:4]}, {12'h000, flags_in - 4'h1});
    run(`OP_SUB_IMM, 8'h00, 8'h01, 3'h0, 1'b0);
    chk({acc, 4'h0, status[3:0]}, 16'h7F09);
    run(`OP_SUB_MEM, 8'h7F, 8'h00, 3'h0, 1'b0);
    chk({acc, 4'h0, status[3:0]}, 16'h7F07);
    chk({7'h00, mem_we, mem_wdata}, 16'h0100);
    run(`OP_SUB_ACC, 8'h80, 8'h00, 3'h0, 1'b0);
    chk({acc, 4'h0, status[3:0]}, 16'hFF0A);
    run(`OP_SWAP_MEM, 8'h3C, 8'h00, 3'h0, 1'b0);
    chk({7'h00, mem_we, mem_wdata}, 16'h01C3);
    run(`OP_SWAP_ACC, 8'h5A, 8'h00, 3'h0, 1'b0);
    chk({acc, 4'h0, status[3:0]}, 16'hA50A);
    chk({7'h00, mem_we, mem_wdata}, 16'h00C3);
    run(`OP_XOR_ACC, 8'hA5, 8'h00, 3'h0, 1'b0);
    chk({acc, 4'h0, status[3:0]}, 16'h000E);
    run(`OP_XOR_MEM, 8'h0F, 8'h00, 3'h0, 1'b0);
    chk({acc, 4'h0, status[3:0]}, 16'h000A);
    chk({7'h00, mem_we, mem_wdata}, 16'h010F);
    foreach (tbl[k]) begin
      run(tbl[k][15:12], tbl[k][7:0], 8'h00, tbl[k][11:9], k == 0);
      if (tbl[k][15:12] == `OP_MOVE_SKIP) acc_x = tbl[k][7:0];
      chk({discard, busy, mem_we, 5'h00, acc}, {tbl[k][8], tbl[k][8], 6'h00, acc_x});
      chk({12'h000, status[3:0]}, 16'h000A);
    end
    run(`OP_TAB_CUR, 8'h34, 8'h12, 3'h0, 1'b0);
    chk({rr, 2'h0, ra}, 16'h9234);
    chk({table_high_latch, mem_wdata}, 16'h1234);
    run(`OP_TAB_LAST, 8'h56, 8'hAB, 3'h0, 1'b0);
    chk({rr, 2'h0, ra}, 16'h9F56);
    chk({table_high_latch, mem_wdata}, 16'hAB56);
    test_done();
  end
endmodule
`default_nettype wire
